// File: dv/ddc_link_tx_assertions.sv
`include "ddc_link_map.vh"
// ========================================
// Port checker for the transmit link
module ddc_link_tx_checker (
  // Clock, reset, settings
  input logic         clk_sys,
  input logic         srst,
  input logic         coding_64b66b,
  input logic         fec_enable,
  input logic [4:0]   lanes_active,
  // Link side
  input logic         sync_req_n,
  input logic         sysref,
  input logic [127:0] lane_octets,
  input logic [15:0]  lane_is_k,
  input logic [1:0]   lane_header,
  input logic         header_slot,
  input logic [15:0]  lane_enable,
  input logic         fec_active,
  input logic         nco_sync,
  input logic         mf_boundary,
  input logic [2:0]   link_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Gap since last boundary; a nearby sysref makes it untrusted
  logic [5:0] gap_q;
  logic       ok_q;
  logic [1:0] sr_q;
  always @(posedge clk_sys) begin
    gap_q <= (srst || mf_boundary) ? 6'h0 : gap_q + 6'h1;
    sr_q  <= {sr_q[0], sysref};
    ok_q  <= (srst || sysref || |sr_q) ? 1'b0 : (mf_boundary ? 1'b1 : ok_q);
  end
  chk_one_hot: assert property ($onehot(link_state))
    else $error("link state not one-hot");
  chk_cgs_entry: assert property (!coding_64b66b && !sync_req_n |=> link_state == 3'h1)
    else $error("sync low did not start code group sync");
  chk_comma_lane: assert property ((!coding_64b66b && lane_enable[0] && link_state == 3'h1)[*2]
    |-> lane_octets[7:0] == `COMMA_K285 && lane_is_k[0])
    else $error("no comma during code group sync");
  // Boundary pulse is registered like the state, so both show up on the same edge
  chk_ilas_start: assert property ($rose(link_state == 3'h2)
    |-> $past(sync_req_n) && mf_boundary)
    else $error("alignment sequence off the multiframe edge");
  chk_mf_period: assert property (mf_boundary && ok_q |-> gap_q == 6'd31)
    else $error("multiframe period wrong");
  chk_fec_flag: assert property (!$past(srst) && $stable(coding_64b66b) && $stable(fec_enable)
    |-> fec_active == (coding_64b66b && fec_enable))
    else $error("fec flag wrong");
  chk_lane_mask: assert property (!$past(srst) && $stable(lanes_active)
    |-> lane_enable == 16'((32'h1 << lanes_active) - 32'h1))
    else $error("lane enable mask wrong");
  chk_nco_pulse: assert property (coding_64b66b && $fell(sync_req_n) |-> ##[0:2] nco_sync)
    else $error("no oscillator sync pulse");
  chk_nco_single: assert property (nco_sync |=> !nco_sync)
    else $error("oscillator sync longer than one cycle");
  chk_nco_8b_quiet: assert property (!$past(srst) && !coding_64b66b |-> !nco_sync)
    else $error("oscillator sync in 8b mode");
  chk_no_hdr_8b: assert property (!$past(srst) && !coding_64b66b
    |-> lane_header == 2'h0 && !header_slot)
    else $error("block header in 8b mode");
  chk_hdr_data: assert property (coding_64b66b && header_slot && link_state == 3'h4
    |-> lane_header == `HDR_DATA)
    else $error("data header wrong");
  // Main scenarios reached
  cover property (link_state == 3'h2);
  cover property (!coding_64b66b && link_state == 3'h4);
  cover property (nco_sync);
endmodule

bind ddc_link_tx ddc_link_tx_checker i_chk (.clk_sys, .srst, .coding_64b66b, .fec_enable,
  .lanes_active, .sync_req_n, .sysref, .lane_octets, .lane_is_k, .lane_header, .header_slot,
  .lane_enable, .fec_active, .nco_sync, .mf_boundary, .link_state);

// File: dv/ddc_serial_link_tx_config_test.sv
`include "ddc_link_map.vh"
// ========================================
// Bench for the transmit link
module ddc_serial_link_tx_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_sys = 1'b0;
  logic         srst, coding_64b66b, gain_boost, fec_enable, sysref, smp_valid, req, slow;
  logic [2:0]   output_mode_select, link_state;
  logic [4:0]   lanes_active;
  logic [14:0]  smp_i, smp_q;
  logic         overrange_flag_first, overrange_flag_second, smp_ready, sync_req_n;
  logic [127:0] lane_octets;
  logic [15:0]  lane_is_k, lane_enable;
  logic [1:0]   lane_header;
  logic         header_slot, fec_active, nco_sync, mf_boundary;
  int           bad_count, num_checks, acc, k;
  // Row: mode, boost, I, Q, flags, lanes, fec, expected word
  typedef struct packed {
    logic [2:0] m; logic b; logic [14:0] i; logic [14:0] q;
    logic o; logic [4:0] la; logic f; logic [31:0] w;
  } row_t;
  row_t rows [5] = '{
    '{`MODE_BYPASS, 1'b0, 15'h1234, 15'h0555, 1'b1, 5'h10, 1'b1, 32'h2469_0000},
    '{`MODE_DEC4,   1'b0, 15'h1234, 15'h0555, 1'b0, 5'h01, 1'b0, 32'h2468_0AAA},
    '{`MODE_DEC8,   1'b1, 15'h1000, 15'h7F00, 1'b1, 5'h08, 1'b1, 32'h4001_FC01},
    '{`MODE_DEC16,  1'b1, 15'h3000, 15'h4800, 1'b0, 5'h04, 1'b0, 32'h7FFE_8000},
    '{`MODE_DEC32,  1'b0, 15'h7FFF, 15'h0001, 1'b1, 5'h10, 1'b1, 32'hFFFF_0003}};
  always #5 clk_sys = ~clk_sys;
  ddc_link_tx i_dut (.clk_sys, .srst, .output_mode_select, .gain_boost, .coding_64b66b,
    .fec_enable, .lanes_active, .smp_valid, .smp_i, .smp_q, .overrange_flag_first,
    .overrange_flag_second, .smp_ready, .sync_req_n, .sysref, .lane_octets, .lane_is_k,
    .lane_header, .header_slot, .lane_enable, .fec_active, .nco_sync, .mf_boundary,
    .link_state);
  link_rx_model i_rx (.clk_sys, .srst, .req, .slow, .octet0(lane_octets[7:0]),
    .is_k0(lane_is_k[0]), .lmfc_edge(mf_boundary), .sync_req_n);
  // Samples taken by the link
  always @(posedge clk_sys) if (!srst && smp_valid && smp_ready) acc <= acc + 1;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reset with new settings, held 3 cycles
  task automatic restart(input logic c, input logic [2:0] m, input logic b,
                         input logic [4:0] la, input logic f);
    @(negedge clk_sys);
    srst = 1'b1; coding_64b66b = c; output_mode_select = m; gain_boost = b;
    lanes_active = la; fec_enable = f; req = 1'b0; acc = 0;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
  endtask
  task automatic pulse_sysref;
    sysref = 1'b1;
    @(negedge clk_sys);
    sysref = 1'b0;
  endtask
  // Word on lane 0, MSB octet at the header slot
  task automatic find_word(input logic [31:0] w);
    for (k = 0; k < 400 && !(header_slot === 1'b1 && lane_octets[7:0] === w[31:24]); k++)
      @(negedge clk_sys);
    check("word octet 3", w[31:24], lane_octets[7:0]);
    for (int n = 2; n >= 0; n--) begin
      @(negedge clk_sys);
      check("word octet", w[8*n+:8], lane_octets[7:0]);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles expected
  initial begin
    #100us;
    bad_count++;
    conclude();
  end
  initial begin
    srst = 1'b1; sysref = 1'b0; smp_valid = 1'b0; req = 1'b0; slow = 1'b0;
    smp_i = 15'h0; smp_q = 15'h0; overrange_flag_first = 1'b0; overrange_flag_second = 1'b0;
    // Table: each mode once, boost set for DEC8 and DEC16 only, in 64B/66B
    foreach (rows[r]) begin
      restart(1'b1, rows[r].m, rows[r].b, rows[r].la, rows[r].f);
      smp_i = rows[r].i; smp_q = rows[r].q; smp_valid = 1'b1;
      overrange_flag_first = rows[r].o; overrange_flag_second = rows[r].o;
      pulse_sysref();
      check("fec active", {31'h0, rows[r].f}, {31'h0, fec_active});
      check("lane enable", (32'h1 << rows[r].la) - 32'h1, {16'h0, lane_enable});
      find_word(rows[r].w);
      $display("row %0d done", r);
    end
    // 8B/10B bring-up against a slow receiver; model latches slow during reset
    slow = 1'b1;
    restart(1'b0, `MODE_BYPASS, 1'b0, 5'h10, 1'b0);
    check("state after reset", 32'h1, {29'h0, link_state});
    req = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("comma lane 15", {4{`COMMA_K285}}, lane_octets[127:96]);
    check("comma flags", 32'hFFFF, {16'h0, lane_is_k});
    for (k = 0; k < 300 && link_state !== 3'h2; k++) @(negedge clk_sys);
    for (k = 0; k < 300 && link_state === 3'h2; k++) @(negedge clk_sys);
    check("alignment length", `ILAS_MF * `MF_LEN, k);
    check("data state", 32'h4, {29'h0, link_state});
    req = 1'b0;
    @(negedge clk_sys);
    req = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("sync again", 32'h1, {29'h0, link_state});
    $display("bring-up done");
    // Buffer filled until refused, then drained
    restart(1'b1, `MODE_BYPASS, 1'b0, 5'h10, 1'b0);
    for (k = 0; k < 20 && smp_ready === 1'b1; k++) @(negedge clk_sys);
    check("refused", 32'h0, {31'h0, smp_ready});
    check("four queued", 32'h1, {31'h0, acc >= 4});
    pulse_sysref();
    for (k = 0; k < 60 && smp_ready !== 1'b1; k++) @(negedge clk_sys);
    check("ready again", 32'h1, {31'h0, smp_ready});
    $display("buffer done");
    // Sync low in 64B/66B only syncs oscillators
    restart(1'b1, `MODE_DEC4, 1'b0, 5'h08, 1'b1);
    pulse_sysref();
    repeat (8) @(negedge clk_sys);
    req = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("nco pulse", 32'h1, {31'h0, nco_sync});
    check("block header", {30'h0, `HDR_DATA}, {30'h0, lane_header});
    repeat (4) @(negedge clk_sys);
    check("state with sync low", 32'h4, {29'h0, link_state});
    req = 1'b0;
    $display("oscillator sync done");
    conclude();
  end
endmodule

// File: dv/link_rx_model.sv
`include "ddc_link_map.vh"
// ========================================
// Receiving logic device: drives the sync handshake
module link_rx_model (
  // Clock and reset
  input  logic       clk_sys,
  input  logic       srst,
  // Bench control: request start, answer a multiframe late
  input  logic       req,
  input  logic       slow,
  // Lane 0 and shared multiframe edge
  input  logic [7:0] octet0,
  input  logic       is_k0,
  input  logic       lmfc_edge,
  // Handshake, low asks for initialization
  output logic       sync_req_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] commas_q = 3'h0;  // Comma run length
  logic       late_q   = 1'b0;  // One extra multiframe pending
  logic       done_q   = 1'b0;  // Sync released
  // Request, count commas, release on a multiframe edge
  always @(posedge clk_sys) begin
    if (srst || !req) begin
      sync_req_n <= 1'b1;  // Idle high
      commas_q   <= 3'h0;
      late_q     <= slow;
      done_q     <= 1'b0;
    end else if (!done_q) begin
      sync_req_n <= 1'b0;  // Held low while aligning
      if (commas_q < 3'h4) begin
        commas_q <= (is_k0 && octet0 == `COMMA_K285) ? commas_q + 3'h1 : 3'h0;
      end else if (lmfc_edge) begin
        late_q     <= 1'b0;
        done_q     <= !late_q;
        sync_req_n <= !late_q;  // Released only on an edge
      end
    end
  end
endmodule

// File: hdl/ddc_decim.v
`include "ddc_link_map.vh"
// ============================================================
// Decimator: averages groups of samples, applies boost, formats words
module ddc_decim (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        srst,
  // Settings
  input  wire [2:0]  output_mode_select,
  input  wire        gain_boost,
  // Input samples, signed 15 bit I and Q
  input  wire        smp_valid,
  input  wire [14:0] smp_i,
  input  wire [14:0] smp_q,
  input  wire        overrange_flag_first,
  input  wire        overrange_flag_second,
  // Formatted output
  output reg         word_valid,
  output reg  [31:0] word_data
);
  reg  [19:0] acc_i_q;   // I accumulator
  reg  [19:0] acc_q_q;   // Q accumulator
  reg  [5:0]  cnt_q;     // Samples in group
  reg         ovr0_q;    // Sticky flags in group
  reg         ovr1_q;
  reg  [5:0]  factor;
  reg  [2:0]  shamt;
  wire [19:0] sum_i;
  wire [19:0] sum_q;
  wire        last;

  // Saturating boost and pack of one 15-bit value
  function [14:0] scale;
    input [19:0] v;
    input [2:0]  sh;
    input        boost;
    reg   [19:0] a;
    begin
      a = $signed(v) >>> sh;
      if (boost)
        a = a <<< `BOOST_SHIFT;
      // Clip rather than wrap
      if ($signed(a) > 20'sd16383)
        scale = 15'h3FFF;
      else if ($signed(a) < -20'sd16384)
        scale = 15'h4000;
      else
        scale = a[14:0];
    end
  endfunction

  // ============================================================
  // Factor from the mode select
  always @* begin
    case (output_mode_select)
      `MODE_DEC4:  begin factor = 6'd4;  shamt = 3'd2; end
      `MODE_DEC8:  begin factor = 6'd8;  shamt = 3'd3; end
      `MODE_DEC16: begin factor = 6'd16; shamt = 3'd4; end
      `MODE_DEC32: begin factor = 6'd32; shamt = 3'd5; end
      default:     begin factor = 6'd1;  shamt = 3'd0; end
    endcase
  end

  assign sum_i = acc_i_q + {{5{smp_i[14]}}, smp_i};
  assign sum_q = acc_q_q + {{5{smp_q[14]}}, smp_q};
  assign last  = (cnt_q == factor - 6'd1);

  // ============================================================
  // Accumulate and emit; unity gain when boost clear
  always @(posedge clk_sys) begin
    if (srst) begin
      acc_i_q    <= 20'h00000;
      acc_q_q    <= 20'h00000;
      cnt_q      <= 6'h00;
      ovr0_q     <= 1'b0;
      ovr1_q     <= 1'b0;
      word_valid <= 1'b0;
      word_data  <= 32'h00000000;
    end else begin
      word_valid <= 1'b0;
      if (smp_valid) begin
        if (last) begin
          word_valid <= 1'b1;
          if (output_mode_select == `MODE_BYPASS) begin
            // Real output: I path only, Q word zero
            word_data <= {scale(sum_i, 3'd0, 1'b0),
                          ovr0_q | overrange_flag_first, 16'h0000};
          end else begin
            word_data <= {scale(sum_i, shamt, gain_boost), ovr0_q | overrange_flag_first,
                          scale(sum_q, shamt, gain_boost),
                          ovr1_q | overrange_flag_second};
          end
          acc_i_q <= 20'h00000;
          acc_q_q <= 20'h00000;
          cnt_q   <= 6'h00;
          ovr0_q  <= 1'b0;
          ovr1_q  <= 1'b0;
        end else begin
          acc_i_q <= sum_i;
          acc_q_q <= sum_q;
          cnt_q   <= cnt_q + 6'd1;
          ovr0_q  <= ovr0_q | overrange_flag_first;
          ovr1_q  <= ovr1_q | overrange_flag_second;
        end
      end
    end
  end
endmodule

// File: hdl/ddc_link_tx.v
`include "ddc_link_map.vh"
// ============================================================
// Transmit link: decimator, FIFO, lane framing for both codings
module ddc_link_tx (
  // Device clock runs all logic and serializer feed
  input  wire         clk_sys,
  input  wire         srst,
  // Settings
  input  wire [2:0]   output_mode_select,
  input  wire         gain_boost,
  input  wire         coding_64b66b,
  input  wire         fec_enable,
  input  wire [4:0]   lanes_active,
  // Sample input
  input  wire         smp_valid,
  input  wire [14:0]  smp_i,
  input  wire [14:0]  smp_q,
  input  wire         overrange_flag_first,
  input  wire         overrange_flag_second,
  output wire         smp_ready,
  // Link side
  input  wire         sync_req_n,
  input  wire         sysref,
  // Lane output, one octet or block header each
  output reg  [127:0] lane_octets,
  output reg  [15:0]  lane_is_k,
  output reg  [1:0]   lane_header,
  output reg          header_slot,
  output reg  [15:0]  lane_enable,
  output reg          fec_active,
  output reg          nco_sync,
  output reg          mf_boundary,
  output wire [2:0]   link_state
);
  // ============================================================
  // Link states, one hot
  localparam ST_CGS  = 3'b001;
  localparam ST_ILAS = 3'b010;
  localparam ST_DATA = 3'b100;

  reg  [2:0]  state_q;    // Link state
  reg  [7:0]  mf_cnt_q;   // Multiframe or multiblock counter
  reg  [2:0]  ilas_q;     // ILAS multiframe count
  reg         sync_q;     // Previous sync level
  reg         sysref_q;   // Previous sysref level
  reg         sref_seen_q;
  reg         ilas_pend_q;
  wire        dec_valid;
  wire [31:0] dec_data;
  wire        f_valid;
  wire [31:0] f_data;
  wire        f_ready;
  wire        sysref_edge;
  wire        mf_end;
  wire        sync_rise;
  wire [1:0]  octet_sel;
  integer     n;

  assign link_state  = state_q;
  assign sysref_edge = sysref & ~sysref_q;
  assign mf_end      = (mf_cnt_q == `MF_LEN - 8'd1);
  assign sync_rise   = sync_req_n & ~sync_q;
  assign octet_sel   = mf_cnt_q[1:0];
  // Only drain samples while carrying data
  assign f_ready     = (state_q == ST_DATA) && (octet_sel == 2'd3);

  // Enable mask for the configured lane count
  function [15:0] lane_mask;
    input [4:0] cnt;
    integer k;
    begin
      lane_mask = 16'h0000;
      for (k = 0; k < `LANES; k = k + 1)
        if (k < cnt)
          lane_mask[k] = 1'b1;
    end
  endfunction

  // ============================================================
  // Decimator and FIFO
  ddc_decim u_decim (
    .clk_sys              (clk_sys),
    .srst                 (srst),
    .output_mode_select   (output_mode_select),
    .gain_boost           (gain_boost),
    .smp_valid            (smp_valid & smp_ready),
    .smp_i                (smp_i),
    .smp_q                (smp_q),
    .overrange_flag_first (overrange_flag_first),
    .overrange_flag_second(overrange_flag_second),
    .word_valid           (dec_valid),
    .word_data            (dec_data)
  );

  // Back-pressure stalls the sample source when full
  sample_fifo #(.WIDTH(32), .DEPTH(`FIFO_DEPTH), .AW(2)) u_fifo (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .in_valid (dec_valid),
    .in_ready (smp_ready),
    .in_data  (dec_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data (f_data)
  );

  // ============================================================
  // Multiframe / multiblock counter; sysref alone realigns it, no multipoint reference
  always @(posedge clk_sys) begin
    if (srst) begin
      mf_cnt_q    <= 8'h00;
      sysref_q    <= 1'b0;
      sref_seen_q <= 1'b0;
    end else begin
      sysref_q <= sysref;
      if (sysref_edge) begin
        mf_cnt_q    <= 8'h00;
        sref_seen_q <= 1'b1;
      end else if (mf_end)
        mf_cnt_q <= 8'h00;
      else
        mf_cnt_q <= mf_cnt_q + 8'd1;
    end
  end

  // ============================================================
  // Link state machine
  always @(posedge clk_sys) begin
    if (srst) begin
      state_q     <= ST_CGS;
      ilas_q      <= 3'h0;
      sync_q      <= 1'b1;
      ilas_pend_q <= 1'b0;
      nco_sync    <= 1'b0;
    end else begin
      sync_q   <= sync_req_n;
      nco_sync <= 1'b0;
      if (coding_64b66b) begin
        // Sync pin only pulses oscillator sync here
        nco_sync    <= ~sync_req_n & sync_q;
        ilas_pend_q <= 1'b0;
        state_q     <= sref_seen_q ? ST_DATA : ST_CGS;
      end else begin
        // Level sampled each cycle: suits either timing revision
        if (!sync_req_n) begin
          state_q     <= ST_CGS;
          ilas_pend_q <= 1'b0;
        end else begin
          if (sync_rise)
            ilas_pend_q <= 1'b1;
          case (state_q)
            ST_CGS: begin
              // Start ILAS on next multiframe edge after release
              if ((ilas_pend_q | sync_rise) && mf_end) begin
                state_q     <= ST_ILAS;
                ilas_q      <= 3'h0;
                ilas_pend_q <= 1'b0;
              end
            end
            ST_ILAS: begin
              if (mf_end) begin
                if (ilas_q == `ILAS_MF - 3'd1)
                  state_q <= ST_DATA;
                ilas_q <= ilas_q + 3'd1;
              end
            end
            ST_DATA: state_q <= ST_DATA;
            default: state_q <= ST_CGS;
          endcase
        end
      end
    end
  end

  // ============================================================
  // Lane output registers
  always @(posedge clk_sys) begin
    if (srst) begin
      lane_octets <= 128'h0;
      lane_is_k   <= 16'h0000;
      lane_header <= 2'h0;
      header_slot <= 1'b0;
      lane_enable <= 16'h0000;
      fec_active  <= 1'b0;
      mf_boundary <= 1'b0;
    end else begin
      lane_enable <= lane_mask((lanes_active > 5'd16) ? 5'd16 : lanes_active);
      fec_active  <= coding_64b66b & fec_enable;
      mf_boundary <= mf_end;
      header_slot <= coding_64b66b && (octet_sel == 2'd0);
      // Data header always: no command channel, no CRC3 bits
      lane_header <= coding_64b66b ? `HDR_DATA : 2'h0;
      for (n = 0; n < `LANES; n = n + 1) begin
        if (!coding_64b66b && state_q == ST_CGS) begin
          lane_octets[n*8 +: 8] <= `COMMA_K285;
          lane_is_k[n]          <= 1'b1;
        end else if (!coding_64b66b && state_q == ST_ILAS) begin
          lane_octets[n*8 +: 8] <= (mf_cnt_q == 8'h00) ? `ILAS_START :
                                   mf_end ? `ILAS_END : mf_cnt_q;
          lane_is_k[n]          <= (mf_cnt_q == 8'h00) | mf_end;
        end else begin
          // Same word on every lane keeps lanes in one link aligned
          lane_octets[n*8 +: 8] <= (f_valid && state_q == ST_DATA) ?
                                   f_data[(3 - octet_sel)*8 +: 8] : 8'h00;
          lane_is_k[n]          <= 1'b0;
        end
      end
    end
  end
endmodule

// File: hdl/sample_fifo.v
// ============================================================
// Small synchronous FIFO with valid/ready on both sides
module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             srst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Storage words
  reg [AW-1:0]    wr_q;              // Write pointer
  reg [AW-1:0]    rd_q;              // Read pointer
  reg [AW:0]      cnt_q;             // Occupancy
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // Registered storage; read is direct from array
  assign out_data  = mem_q[rd_q];

  // ============================================================
  // Pointers and count
  always @(posedge clk_sys) begin
    if (srst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      // Simultaneous push and pop keep count
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// File: shared/ddc_link_map.vh
// ============================================================
// Overview of operation
// - Bypass mode: no decimation, real samples out
// - Decimate by 4/8/16/32 with complex output
// - Boost set: chain gain 6.02 dB in decimating modes, 0 dB in bypass
// - Boost clear: chain gain 0 dB
// - Up to 16 serialized output lanes
// - Lanes use 8B/10B or 64B/66B coding
// - Low sync request starts code group sync in 8B/10B
// - 64B/66B aligns on sync headers, not sync
// - 64B/66B sync input only syncs oscillators
// - One device clock runs logic and serializers
// - Sysref resets multiframe or multiblock counter
// - No command channel in 64B/66B blocks
// - Optional forward error correction in 64B/66B
// - No CRC3 field in 64B/66B mode
// - Physical sync pin input in 8B/10B
// - Subclass 1 transmitter only
// - Lane alignment within one link only
// - No multipoint reference alignment
// - Sync timing suits both standard revisions
// - 15-bit I/Q word plus overrange flag LSB
// - Sync request answered by comma stream in 8B/10B
`ifndef DDC_LINK_MAP_VH
`define DDC_LINK_MAP_VH
// ============================================================
// Output mode select codes
`define MODE_BYPASS   3'h0
`define MODE_DEC4     3'h1
`define MODE_DEC8     3'h2
`define MODE_DEC16    3'h3
`define MODE_DEC32    3'h4
// ============================================================
// Link geometry and coding
`define LANES         16
`define SAMPLE_W      16
`define DATA_W        15
`define OCTET_W       8
`define COMMA_K285    8'hBC
`define ILAS_FILL     8'h1C
`define ILAS_START    8'h1C
`define ILAS_END      8'h7C
`define HDR_DATA      2'h1
`define HDR_CTRL      2'h2
// Multiframe length in frames and frames per block
`define MF_LEN        8'h20
`define MB_LEN        8'h20
`define ILAS_MF       3'h4
// Gain of 6.02 dB is a left shift of one
`define BOOST_SHIFT   1
`define FIFO_DEPTH    4
`endif
